// file: core/twm_cfg.svh
// Constants for the timer waveform block: register offsets, field positions,
// reset values and prescaler taps. Definitions only.
`ifndef TWM_CFG_SVH
`define TWM_CFG_SVH

`define TWM_OFS_CTRL_A 8'h00
`define TWM_OFS_CTRL_B 8'h04
`define TWM_OFS_COUNT 8'h08
`define TWM_OFS_CMP_A 8'h0C
`define TWM_OFS_CMP_B 8'h10
`define TWM_OFS_FLAGS 8'h14

`define TWM_CTRL_A_RST 8'h00
`define TWM_CTRL_A_RMASK 8'hF3
`define TWM_BYTE_ZERO 8'h00
`define TWM_BYTE_ONE 8'h01
`define TWM_BYTE_MAX 8'hFF

`define TWM_A_ACT_HI 7
`define TWM_A_ACT_LO 6
`define TWM_B_ACT_HI 5
`define TWM_B_ACT_LO 4
`define TWM_WS_LOW_HI 1
`define TWM_WS_LOW_LO 0
`define TWM_FORCE_A_BIT 7
`define TWM_FORCE_B_BIT 6
`define TWM_WS_HIGH_BIT 3
`define TWM_CS_HI 2
`define TWM_CS_LO 0
`define TWM_WRAP_BIT 1
`define TWM_MATCH_A_BIT 2
`define TWM_MATCH_B_BIT 3

`define TWM_ACT_OFF 2'h0
`define TWM_ACT_TOGGLE 2'h1
`define TWM_ACT_CLEAR 2'h2
`define TWM_ACT_SET 2'h3

`define TWM_MODE_NORMAL 3'h0
`define TWM_MODE_PC_MAX 3'h1
`define TWM_MODE_CTC 3'h2
`define TWM_MODE_FAST_MAX 3'h3
`define TWM_MODE_PC_CMP 3'h5
`define TWM_MODE_FAST_CMP 3'h7

`define TWM_CS_STOP 3'h0
`define TWM_CS_DIV1 3'h1
`define TWM_CS_DIV8 3'h2
`define TWM_CS_DIV64 3'h3
`define TWM_CS_DIV256 3'h4
`define TWM_CS_DIV1024 3'h5
`define TWM_CS_EXT_FALL 3'h6
`define TWM_CS_EXT_RISE 3'h7

`define TWM_PRE_W 10
`define TWM_PRE_MASK8 10'h007
`define TWM_PRE_MASK64 10'h03F
`define TWM_PRE_MASK256 10'h0FF
`define TWM_PRE_MASK1024 10'h3FF

`define TWM_HTRANS_NONSEQ_BIT 1

`endif

// file: core/twm_pkg.sv
// Types shared by the timer waveform block.
// Assumes twm_cfg.svh holds the numeric constants.
package twm_pkg;
	typedef enum logic {TWM_DIR_UP, TWM_DIR_DOWN} twm_dir_t;
	typedef logic [1:0] twm_action_t;
	typedef logic [2:0] twm_mode_t;
	typedef logic [7:0] twm_byte_t;
endpackage

// file: core/twm_timer.sv
// 8-bit timer/counter with two waveform outputs, AHB-Lite register slave.
// Assumes a single 25 MHz core_clk, a synchronous reset and one AHB master.
//
// Notes on behaviour
// R1 - Codes 1 and 5 give phase-correct PWM
// R2 - Phase-correct counts up to top, then down
// R3 - Count holds top for exactly one tick
// R4 - Phase-correct wrap flag set at zero
// R5 - Code 10: clear up-match, set down-match
// R6 - Code 11: set up-match, clear down-match
// R7 - Channel A code 01 toggles if high bit
// R8 - Channel B code 01 reserved in PWM
// R9 - Compare zero low, maximum high, inverted opposite
// R10 - Symmetry transitions without a compare match
// R11 - Nonzero action overrides port; direction still needed
// R12 - Non-PWM codes: off, toggle, clear, set
// R13 - Fast PWM: match clears/sets, top sets/clears
// R14 - Compare equal top ignored, act at top
// R15 - Three-bit select chooses mode and top
// R16 - Compare update timing and wrap flag point
// R17 - Phase-correct period is 510 ticks
// R18 - Tick is a clock enable only
// R19 - Control A bits 3:2 read zero
// R20 - Select high bit in control B bit 3
// R21 - Compare every tick, one-tick match events; code skips the tick after a count write
`timescale 1ns/1ps
`include "twm_cfg.svh"

module twm_timer
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic ext_clk_pin,
	input wire logic port_a_data,
	input wire logic port_a_dir,
	input wire logic port_b_data,
	input wire logic port_b_dir,
	output logic pin_a_out,
	output logic pin_a_oe,
	output logic pin_b_out,
	output logic pin_b_oe,
	output logic wrap_flag,
	output logic match_a_flag,
	output logic match_b_flag
);
	import twm_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Register state

	twm_action_t output_a_action;
	twm_action_t output_b_action;
	logic [1:0] waveform_select_low;
	logic waveform_select_high;
	logic [2:0] clock_select_q;
	twm_byte_t count_value;
	twm_byte_t cmp_buf_q [2];
	twm_byte_t cmp_act_q [2];
	logic wrap_q;
	logic [1:0] match_q;
	logic block_q;
	twm_dir_t dir_q;
	logic [1:0] wave_q;

	logic ph_valid_q;
	logic ph_write_q;
	logic [7:0] ph_addr_q;
	logic wr_en;
	logic [7:0] wbyte;
	logic [31:0] rd_d;

	////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave, zero wait states, always OKAY

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign wr_en = ph_valid_q && ph_write_q;
	assign wbyte = hwdata[7:0];

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			ph_valid_q <= 1'b0;
			ph_write_q <= 1'b0;
			ph_addr_q <= `TWM_BYTE_ZERO;
		end
		else if (hready)
		begin
			ph_valid_q <= hsel && htrans[`TWM_HTRANS_NONSEQ_BIT];
			ph_write_q <= hwrite;
			ph_addr_q <= haddr;
		end
	end

	// R19 reserved bits read zero
	always_comb
	begin
		rd_d = 32'h0000_0000;
		case (haddr)
			`TWM_OFS_CTRL_A: rd_d[7:0] = {output_a_action, output_b_action, 2'b00,
				waveform_select_low};
			`TWM_OFS_CTRL_B: rd_d[7:0] = {4'h0, waveform_select_high, clock_select_q};
			`TWM_OFS_COUNT: rd_d[7:0] = count_value;
			`TWM_OFS_CMP_A: rd_d[7:0] = cmp_buf_q[0];
			`TWM_OFS_CMP_B: rd_d[7:0] = cmp_buf_q[1];
			`TWM_OFS_FLAGS: rd_d[7:0] = {4'h0, match_q[1], match_q[0], wrap_q, 1'b0};
			default: rd_d = 32'h0000_0000;
		endcase
	end

	// Read data captured in the address phase
	always_ff @(posedge core_clk)
	begin
		if (rst)
			hrdata <= 32'h0000_0000;
		else if (hready && hsel && htrans[`TWM_HTRANS_NONSEQ_BIT] && !hwrite)
			hrdata <= rd_d;
	end

	// R19 writes to reserved bits dropped
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			output_a_action <= `TWM_ACT_OFF;
			output_b_action <= `TWM_ACT_OFF;
			waveform_select_low <= 2'b00;
		end
		else if (wr_en && ph_addr_q == `TWM_OFS_CTRL_A)
		begin
			output_a_action <= wbyte[`TWM_A_ACT_HI:`TWM_A_ACT_LO];
			output_b_action <= wbyte[`TWM_B_ACT_HI:`TWM_B_ACT_LO];
			waveform_select_low <= wbyte[`TWM_WS_LOW_HI:`TWM_WS_LOW_LO];
		end
	end

	// R20 select high bit in control B
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			waveform_select_high <= 1'b0;
			clock_select_q <= `TWM_CS_STOP;
		end
		else if (wr_en && ph_addr_q == `TWM_OFS_CTRL_B)
		begin
			waveform_select_high <= wbyte[`TWM_WS_HIGH_BIT];
			clock_select_q <= wbyte[`TWM_CS_HI:`TWM_CS_LO];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Mode decode and prescaler

	twm_mode_t mode;
	logic is_pc;
	logic is_fast;
	logic is_pwm;
	logic is_reserved;
	logic [`TWM_PRE_W-1:0] pre_q;
	logic ext_s1_q;
	logic ext_s2_q;
	logic ext_s3_q;
	logic tick;
	twm_byte_t top;
	logic at_top;
	logic at_bottom;
	logic [1:0] force_stb;

	// R15 mode select
	assign mode = {waveform_select_high, waveform_select_low};
	// R1 phase-correct codes
	assign is_pc = (mode == `TWM_MODE_PC_MAX) || (mode == `TWM_MODE_PC_CMP);
	assign is_fast = (mode == `TWM_MODE_FAST_MAX) || (mode == `TWM_MODE_FAST_CMP);
	assign is_pwm = is_pc || is_fast;
	assign is_reserved = waveform_select_high && !waveform_select_low[0];
	// R15 turn-around per mode
	assign top = (mode == `TWM_MODE_CTC || mode == `TWM_MODE_PC_CMP ||
		mode == `TWM_MODE_FAST_CMP) ? cmp_act_q[0] : `TWM_BYTE_MAX;

	always_ff @(posedge core_clk)
	begin
		if (rst)
			pre_q <= '0;
		else
			pre_q <= pre_q + `TWM_PRE_W'(1);
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
		end
		else
		begin
			ext_s1_q <= ext_clk_pin;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
		end
	end

	// R18 tick is an enable on core_clk
	always_comb
	begin
		case (clock_select_q)
			`TWM_CS_DIV1: tick = 1'b1;
			`TWM_CS_DIV8: tick = (pre_q & `TWM_PRE_MASK8) == `TWM_PRE_MASK8;
			`TWM_CS_DIV64: tick = (pre_q & `TWM_PRE_MASK64) == `TWM_PRE_MASK64;
			`TWM_CS_DIV256: tick = (pre_q & `TWM_PRE_MASK256) == `TWM_PRE_MASK256;
			`TWM_CS_DIV1024: tick = pre_q == `TWM_PRE_MASK1024;
			`TWM_CS_EXT_FALL: tick = ext_s3_q && !ext_s2_q;
			`TWM_CS_EXT_RISE: tick = !ext_s3_q && ext_s2_q;
			default: tick = 1'b0;
		endcase
	end

	assign at_top = tick && (count_value == top);
	assign at_bottom = tick && (count_value == `TWM_BYTE_ZERO);
	assign force_stb[0] = wr_en && ph_addr_q == `TWM_OFS_CTRL_B && wbyte[`TWM_FORCE_A_BIT];
	assign force_stb[1] = wr_en && ph_addr_q == `TWM_OFS_CTRL_B && wbyte[`TWM_FORCE_B_BIT];

	////////////////////////////////////////////////////////////////////////////
	// Counter

	// R2 up then down, R3 one tick at top, R17 510 ticks at 0xFF
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			count_value <= `TWM_BYTE_ZERO;
			dir_q <= TWM_DIR_UP;
			block_q <= 1'b0;
		end
		else if (wr_en && ph_addr_q == `TWM_OFS_COUNT)
		begin
			count_value <= wbyte;
			block_q <= 1'b1;
		end
		else if (tick)
		begin
			block_q <= 1'b0;
			if (is_reserved)
				count_value <= count_value;
			else if (is_pc)
			begin
				if (top == `TWM_BYTE_ZERO)
				begin
					count_value <= `TWM_BYTE_ZERO;
					dir_q <= TWM_DIR_UP;
				end
				else if (dir_q == TWM_DIR_UP && count_value >= top)
				begin
					count_value <= count_value - `TWM_BYTE_ONE;
					dir_q <= TWM_DIR_DOWN;
				end
				else if (dir_q == TWM_DIR_DOWN && count_value == `TWM_BYTE_ZERO)
				begin
					count_value <= `TWM_BYTE_ONE;
					dir_q <= TWM_DIR_UP;
				end
				else if (dir_q == TWM_DIR_UP)
					count_value <= count_value + `TWM_BYTE_ONE;
				else
					count_value <= count_value - `TWM_BYTE_ONE;
			end
			else
			begin
				dir_q <= TWM_DIR_UP;
				if (mode != `TWM_MODE_NORMAL && count_value == top)
					count_value <= `TWM_BYTE_ZERO;
				else
					count_value <= count_value + `TWM_BYTE_ONE;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Flags

	logic [1:0] match_ev;
	logic wrap_ev;

	// R4 R16 wrap point per mode
	always_comb
	begin
		if (is_pc)
			wrap_ev = at_bottom;
		else if (mode == `TWM_MODE_FAST_CMP)
			wrap_ev = at_top;
		else if (is_reserved)
			wrap_ev = 1'b0;
		else
			wrap_ev = tick && count_value == `TWM_BYTE_MAX;
	end

	// Set wins over write-one-to-clear
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			wrap_q <= 1'b0;
			match_q <= 2'b00;
		end
		else
		begin
			wrap_q <= wrap_ev || (wrap_q && !(wr_en && ph_addr_q == `TWM_OFS_FLAGS &&
				wbyte[`TWM_WRAP_BIT]));
			match_q[0] <= match_ev[0] || (match_q[0] && !(wr_en &&
				ph_addr_q == `TWM_OFS_FLAGS && wbyte[`TWM_MATCH_A_BIT]));
			match_q[1] <= match_ev[1] || (match_q[1] && !(wr_en &&
				ph_addr_q == `TWM_OFS_FLAGS && wbyte[`TWM_MATCH_B_BIT]));
		end
	end

	assign wrap_flag = wrap_q;
	assign match_a_flag = match_q[0];
	assign match_b_flag = match_q[1];

	////////////////////////////////////////////////////////////////////////////
	// Compare units and waveform outputs, one per channel

	logic [1:0] connected;

	for (genvar ch = 0; ch < 2; ch++)
	begin : g_chan
		twm_action_t act;
		logic cmp_wr;
		logic cmp_eq_top;
		logic up_match;
		logic up_res;
		logic toggle_ok;

		assign act = (ch == 0) ? output_a_action : output_b_action;
		assign cmp_wr = wr_en && ph_addr_q == ((ch == 0) ? `TWM_OFS_CMP_A : `TWM_OFS_CMP_B);
		// R21 compare on every tick, except the first tick after a count write and in reserved modes
		assign match_ev[ch] = tick && !block_q && !is_reserved &&
			count_value == cmp_act_q[ch];
		assign cmp_eq_top = cmp_act_q[ch] == top;
		assign up_match = dir_q == TWM_DIR_UP || count_value == `TWM_BYTE_ZERO;
		assign up_res = act == `TWM_ACT_SET;
		// R7 channel A toggle needs high bit; R8 channel B never
		assign toggle_ok = (ch == 0) && waveform_select_high;
		// R11 nonzero action takes the pin, except a reserved PWM toggle (no toggle_ok)
		assign connected[ch] = act != `TWM_ACT_OFF &&
			!(is_pwm && act == `TWM_ACT_TOGGLE && !toggle_ok);

		always_ff @(posedge core_clk)
		begin
			if (rst)
				cmp_buf_q[ch] <= `TWM_BYTE_ZERO;
			else if (cmp_wr)
				cmp_buf_q[ch] <= wbyte;
		end

		// R16 immediate in non-PWM, at top in PWM
		always_ff @(posedge core_clk)
		begin
			if (rst)
				cmp_act_q[ch] <= `TWM_BYTE_ZERO;
			else if (!is_pwm)
				cmp_act_q[ch] <= cmp_wr ? wbyte : cmp_buf_q[ch];
			else if (at_top)
				cmp_act_q[ch] <= cmp_buf_q[ch];
		end

		always_ff @(posedge core_clk)
		begin
			if (rst)
				wave_q[ch] <= 1'b0;
			else if (!is_pwm)
			begin
				// R12 non-PWM actions, also forced strobes
				if (match_ev[ch] || force_stb[ch])
				begin
					case (act)
						`TWM_ACT_TOGGLE: wave_q[ch] <= !wave_q[ch];
						`TWM_ACT_CLEAR: wave_q[ch] <= 1'b0;
						`TWM_ACT_SET: wave_q[ch] <= 1'b1;
						default: wave_q[ch] <= wave_q[ch];
					endcase
				end
			end
			else if (act == `TWM_ACT_TOGGLE)
			begin
				// R7 toggle on match
				if (toggle_ok && match_ev[ch])
					wave_q[ch] <= !wave_q[ch];
			end
			else if (act[1])
			begin
				if (is_fast)
				begin
					// R13 R14 top action, match ignored when equal top
					if (at_top)
						wave_q[ch] <= !up_res;
					else if (match_ev[ch] && !cmp_eq_top)
						wave_q[ch] <= up_res;
				end
				else
				begin
					// R10 R14 symmetry and equal-top handling at top, R9 extremes
					if (at_top)
						wave_q[ch] <= (cmp_buf_q[ch] == top) ? !up_res : up_res;
					// R5 R6 direction-dependent match action
					else if (match_ev[ch])
						wave_q[ch] <= up_match ? up_res : !up_res;
				end
			end
		end
	end

	// R11 pin driver still follows direction bit
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			pin_a_out <= 1'b0;
			pin_b_out <= 1'b0;
			pin_a_oe <= 1'b0;
			pin_b_oe <= 1'b0;
		end
		else
		begin
			pin_a_out <= connected[0] ? wave_q[0] : port_a_data;
			pin_b_out <= connected[1] ? wave_q[1] : port_b_data;
			pin_a_oe <= port_a_dir;
			pin_b_oe <= port_b_dir;
		end
	end
endmodule

// file: tb/twm_timer_assertions.sv
// Checker of the timer waveform block, bound to twm_timer.
// Assumes word AHB-Lite accesses and a synchronous reset.
`timescale 1ns/1ps
`include "twm_cfg.svh"
module twm_timer_assertions
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic hresp,
	input wire logic port_a_data,
	input wire logic port_a_dir,
	input wire logic pin_a_out,
	input wire logic pin_a_oe,
	input wire logic wrap_flag,
	input wire logic match_a_flag
);
	logic take, wr_q, rsv, clr_w, clr_m;
	logic [7:0] adr_q, ctl_a_q, ctl_b_q;
	logic [2:0] stop_q;
	assign take = hready && hsel && htrans[1];
	assign rsv = ctl_b_q[3] && !ctl_a_q[0];
	assign clr_w = wr_q && adr_q == `TWM_OFS_FLAGS && hwdata[`TWM_WRAP_BIT];
	assign clr_m = wr_q && adr_q == `TWM_OFS_FLAGS && hwdata[`TWM_MATCH_A_BIT];
	always_ff @(posedge core_clk)
	begin
		wr_q <= take && hwrite && !rst;
		adr_q <= haddr;
	end
	// Shadow of both control registers
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			ctl_a_q <= 8'h00;
			ctl_b_q <= 8'h00;
		end
		else if (wr_q && adr_q == `TWM_OFS_CTRL_A)
			ctl_a_q <= hwdata[7:0];
		else if (wr_q && adr_q == `TWM_OFS_CTRL_B)
			ctl_b_q <= hwdata[7:0];
	end
	always_ff @(posedge core_clk)
	begin
		if (rst || ctl_b_q[2:0] != 3'h0)
			stop_q <= 3'h0;
		else if (stop_q != 3'h7)
			stop_q <= stop_q + 3'h1;
	end
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	sequence s_rd_ctl_a;
		take && !hwrite && haddr == `TWM_OFS_CTRL_A;
	endsequence
	AST_BUS_OKAY:
		assert property (hreadyout && !hresp && hrdata[31:8] == 24'h0)
		else $error("bus answer not ready, okay and byte wide");
	AST_CTL_A_READ:
		assert property (s_rd_ctl_a |=> hrdata[7:0] == ($past(ctl_a_q) & `TWM_CTRL_A_RMASK))
		else $error("control A read back wrong");
	AST_WRAP_CLEAR:
		assert property (!$past(rst) && $fell(wrap_flag) |-> $past(clr_w))
		else $error("wrap flag fell without a clear");
	AST_MATCH_CLEAR:
		assert property (!$past(rst) && $fell(match_a_flag) |-> $past(clr_m))
		else $error("match flag fell without a clear");
	AST_OE_A:
		assert property (!$past(rst) |-> pin_a_oe == $past(port_a_dir))
		else $error("enable does not follow direction");
	AST_PORT_A:
		assert property (!$past(rst) && $past(ctl_a_q[7:6]) == 2'h0
			|-> pin_a_out == $past(port_a_data))
		else $error("disconnected pin not at port level");
	AST_RSV_MODE:
		assert property (rsv [*4] |=> !$rose(wrap_flag) && !$rose(match_a_flag))
		else $error("event in a reserved mode");
	AST_STOPPED:
		assert property (stop_q == 3'h7 |-> !$rose(wrap_flag) && !$rose(match_a_flag))
		else $error("event while the timer is stopped");
endmodule
bind twm_timer twm_timer_assertions u_twm_chk (.core_clk(core_clk), .rst(rst), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .port_a_data(port_a_data),
	.port_a_dir(port_a_dir), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe),
	.wrap_flag(wrap_flag), .match_a_flag(match_a_flag));

// file: tb/twm_load_model.sv
// Loads on the two waveform pins.
// Assumes a pin enable is high while the timer drives; released lines pull low.
`timescale 1ns/1ps
module twm_load_model
(
	input wire logic pin_a_out,
	input wire logic pin_a_oe,
	input wire logic pin_b_out,
	input wire logic pin_b_oe,
	output logic line_a,
	output logic line_b
);
	assign line_a = pin_a_oe ? pin_a_out : 1'b0;
	assign line_b = pin_b_oe ? pin_b_out : 1'b0;
endmodule

// file: tb/twm_timer_tb_top.sv
// Bench of twm_timer: registers, waveform shapes, flags and pin release.
// Assumes the load model on both pins and a zero-wait bus slave.
`timescale 1ns/1ps
`include "twm_cfg.svh"
module twm_timer_tb_top;
	import twm_pkg::*;
	typedef struct {twm_mode_t m; twm_action_t act; logic ch; twm_byte_t ca;
		int hi; int per;} twm_row_t;
	logic core_clk, rst, hsel, hwrite, pa_d, pa_dir, line_a, line_b, ext_pin;
	logic hreadyout, hresp, pao, paoe, pbo, pboe, wrap_flag, mfa, mfb;
	logic [7:0] haddr;
	logic [1:0] htrans;
	logic [31:0] hwdata, hrdata;
	twm_byte_t rd;
	int n_fail = 0;
	int total_checks = 0;
	int hi, lo;
	twm_row_t rows [9] = '{
		'{3'h1, 2'h2, 1'b0, 8'h40, 128, 510},
		'{3'h1, 2'h3, 1'b0, 8'h40, 382, 510},
		'{3'h3, 2'h2, 1'b0, 8'h40, 65, 256},
		'{3'h3, 2'h3, 1'b0, 8'h40, 191, 256},
		'{3'h0, 2'h1, 1'b0, 8'h10, 256, 512},
		'{3'h2, 2'h1, 1'b0, 8'h1F, 32, 64},
		'{3'h5, 2'h1, 1'b0, 8'h40, 128, 256},
		'{3'h5, 2'h2, 1'b1, 8'h80, 64, 256},
		'{3'h7, 2'h2, 1'b1, 8'h7F, 33, 128}};
	twm_timer DUT (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .ext_clk_pin(ext_pin),
		.port_a_data(pa_d), .port_a_dir(pa_dir), .port_b_data(1'b0), .port_b_dir(1'b1),
		.pin_a_out(pao), .pin_a_oe(paoe), .pin_b_out(pbo), .pin_b_oe(pboe),
		.wrap_flag(wrap_flag), .match_a_flag(mfa), .match_b_flag(mfb));
	twm_load_model LOAD (.pin_a_out(pao), .pin_a_oe(paoe), .pin_b_out(pbo), .pin_b_oe(pboe),
		.line_a(line_a), .line_b(line_b));
	task automatic chk_b(input string n, input twm_byte_t e, input twm_byte_t g);
		total_checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_n(input string n, input int e, input int g);
		total_checks++;
		if (g != e)
		begin
			n_fail++;
			$display("ERROR %s expected %0d seen %0d", n, e, g);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input twm_byte_t d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rd = hrdata[7:0];
	endtask
	task automatic setup(input twm_mode_t m, input logic [3:0] act, input twm_byte_t ca);
		xfer(1'b1, `TWM_OFS_CTRL_B, 8'h00);
		xfer(1'b1, `TWM_OFS_COUNT, 8'h00);
		xfer(1'b1, `TWM_OFS_CMP_A, ca);
		xfer(1'b1, `TWM_OFS_CMP_B, 8'h20);
		xfer(1'b1, `TWM_OFS_CTRL_A, {act, 2'h0, m[1:0]});
		xfer(1'b1, `TWM_OFS_CTRL_B, {4'h0, m[2], 3'h1});
	endtask
	function automatic logic ln(input logic ch);
		return ch ? line_b : line_a;
	endfunction
	task automatic cnt(input logic ch, input logic v, output int k);
		k = 0;
		while (ln(ch) === v && k < 3000)
		begin
			@(posedge core_clk);
			k++;
		end
	endtask
	task automatic flat(input logic ch, input logic e);
		int k;
		k = 0;
		repeat (600)
		begin
			@(posedge core_clk);
			if (ln(ch) !== e)
				k++;
		end
		chk_n("off-level cycles", 0, k);
	endtask
	// Measures one high and one low span after two settling periods
	task automatic span(input logic ch);
		// Skip periods run on a stale compare value
		repeat (2)
		begin
			cnt(ch, 1'b0, hi);
			cnt(ch, 1'b1, hi);
		end
		cnt(ch, 1'b0, hi);
		cnt(ch, 1'b1, hi);
		cnt(ch, 1'b0, lo);
	endtask
	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	initial
	begin
		repeat (80000) @(posedge core_clk);
		n_fail++;
		complete_run();
	end
	initial
	begin
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'h0;
		haddr = 8'h00;
		hwdata = 32'h0;
		pa_d = 1'b0;
		pa_dir = 1'b0;
		ext_pin = 1'b0;
		rst = 1'b1;
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		pa_dir <= 1'b1;
		@(posedge core_clk);
		xfer(1'b0, `TWM_OFS_CTRL_A, 8'h00);
		chk_b("ctrl_a reset", 8'h00, rd);
		xfer(1'b1, `TWM_OFS_CTRL_A, 8'hFF);
		xfer(1'b0, `TWM_OFS_CTRL_A, 8'h00);
		chk_b("ctrl_a", 8'hF3, rd);
		xfer(1'b1, 8'h20, 8'hFF);
		xfer(1'b0, 8'h20, 8'h00);
		chk_b("unmapped", 8'h00, rd);
		foreach (rows[i])
		begin
			setup(rows[i].m, rows[i].ch ? {2'h0, rows[i].act} : {rows[i].act, 2'h0}, rows[i].ca);
			span(rows[i].ch);
			chk_n("high ticks", rows[i].hi, hi);
			chk_n("period ticks", rows[i].per, hi + lo);
		end
		for (int k = 0; k < 2; k++)
		begin
			setup(3'h1, 4'h8, k[0] ? 8'hFF : 8'h00);
			repeat (1100) @(posedge core_clk);
			flat(1'b0, k[0]);
		end
		// Divide-by-8 tick on a phase-correct period
		setup(3'h1, 4'h8, 8'h80);
		xfer(1'b1, `TWM_OFS_CTRL_B, 8'h02);
		span(1'b0);
		chk_n("prescaled high", 2048, hi);
		chk_n("prescaled period", 4080, hi + lo);
		setup(3'h1, 4'h5, 8'h40);
		pa_d <= 1'b1;
		repeat (1100) @(posedge core_clk);
		flat(1'b0, 1'b1);
		flat(1'b1, 1'b0);
		// Channel B toggle stays reserved with the high select bit set
		setup(3'h5, 4'h5, 8'h40);
		repeat (300) @(posedge core_clk);
		flat(1'b1, 1'b0);
		pa_dir <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk_b("released line", 8'h00, {7'h0, line_a});
		xfer(1'b1, `TWM_OFS_CTRL_B, 8'h00);
		xfer(1'b1, `TWM_OFS_FLAGS, 8'h0E);
		@(posedge core_clk);
		chk_b("flags cleared", 8'h00, {5'h0, wrap_flag, mfa, mfb});
		xfer(1'b1, `TWM_OFS_CTRL_B, 8'h01);
		hi = 0;
		while (wrap_flag !== 1'b1 && hi < 600)
		begin
			@(posedge core_clk);
			hi++;
		end
		xfer(1'b0, `TWM_OFS_COUNT, 8'h00);
		chk_n("count after wrap", 1, int'(rd < 8'h08));
		repeat (100) @(posedge core_clk);
		chk_b("match flags", 8'h03, {6'h0, mfa, mfb});
		xfer(1'b1, `TWM_OFS_CTRL_A, 8'h00);
		xfer(1'b1, `TWM_OFS_CTRL_B, 8'h09);
		xfer(1'b1, `TWM_OFS_FLAGS, 8'h0E);
		repeat (600) @(posedge core_clk);
		chk_b("reserved mode flags", 8'h00, {5'h0, wrap_flag, mfa, mfb});
		// Forced compare strobes in normal mode, timer stopped
		xfer(1'b1, `TWM_OFS_CTRL_B, 8'h00);
		xfer(1'b1, `TWM_OFS_CTRL_A, 8'h80);
		pa_dir <= 1'b1;
		xfer(1'b1, `TWM_OFS_CTRL_B, 8'h80);
		repeat (2) @(posedge core_clk);
		chk_b("forced clear", 8'h00, {7'h0, line_a});
		xfer(1'b1, `TWM_OFS_CTRL_A, 8'hC0);
		xfer(1'b1, `TWM_OFS_CTRL_B, 8'h80);
		repeat (2) @(posedge core_clk);
		chk_b("forced set", 8'h01, {6'h0, mfa, line_a});
		// External rising edges as the tick
		xfer(1'b1, `TWM_OFS_COUNT, 8'h00);
		xfer(1'b1, `TWM_OFS_CTRL_B, 8'h07);
		repeat (5)
		begin
			ext_pin <= 1'b1;
			repeat (2) @(posedge core_clk);
			ext_pin <= 1'b0;
			repeat (2) @(posedge core_clk);
		end
		xfer(1'b0, `TWM_OFS_COUNT, 8'h00);
		chk_b("external count", 8'h05, rd);
		complete_run();
	end
endmodule
